// File: iov_pkg.sv
// constants, types and helpers for the input over-voltage fault handler
// assumes a 100 MHz core clock and a separate command-link clock
`default_nettype none

package iov_pkg;

  localparam int CMD_W  = 8;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;

  // command codes
  localparam logic [CMD_W-1:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [CMD_W-1:0] CMD_FAULT_THR    = 8'h55;
  localparam logic [CMD_W-1:0] CMD_ACTION       = 8'h56;
  localparam logic [CMD_W-1:0] CMD_WARN_THR     = 8'h57;
  localparam logic [CMD_W-1:0] CMD_STATUS       = 8'h7C;
  localparam logic [CMD_W-1:0] CMD_TIME_UNIT    = 8'hD2;

  // action byte layout
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB   = 2;
  localparam int DLY_LSB   = 0;

  // status byte layout
  localparam int ST_FAULT_BIT = 7;
  localparam int ST_WARN_BIT  = 5;

  // reset values; thresholds start at the largest positive linear value
  localparam logic [DATA_W-1:0] FAULT_THR_RST = 16'h7BFF;
  localparam logic [DATA_W-1:0] WARN_THR_RST  = 16'h7BFF;
  localparam logic [7:0]        ACTION_RST    = 8'h00;
  localparam logic [DATA_W-1:0] TIME_UNIT_RST = 16'h0001;

  typedef enum logic [1:0] {
    RESP_IGNORE = 2'h0,
    RESP_RIDE   = 2'h1,
    RESP_RETRY  = 2'h2,
    RESP_LATCH  = 2'h3
  } iov_resp_t;

  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;

  // gray order along run -> ride -> wait -> latched
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_RIDE  = 2'b01,
    ST_WAIT  = 2'b11,
    ST_LATCH = 2'b10
  } iov_state_t;

  // time base: one delay unit step is one microsecond times the unit register
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         TICK_NS       = 1000;
  localparam logic [6:0] TICK_CYC_M1   = 7'(TICK_NS / CLK_PERIOD_NS - 1);
  localparam logic [7:0] TMR_LAST      = 8'h01;
  localparam logic [7:0] MULT_ONE      = 8'h01;

  // linear format (5-bit exponent, 11-bit mantissa) to 32.16-style fixed point
  function automatic logic signed [47:0] iov_lin_to_fix(input logic [15:0] v);
    logic signed [4:0]  e;
    logic signed [6:0]  sh;
    logic signed [47:0] m;
    e  = v[15:11];
    sh = 7'(e) + 7'sd16;
    m  = {{37{v[10]}}, v[10:0]};
    return m <<< sh[4:0];
  endfunction : iov_lin_to_fix

  function automatic logic [7:0] iov_mult(input logic [2:0] code);
    return MULT_ONE << code;
  endfunction : iov_mult

endpackage : iov_pkg

`default_nettype wire

// File: iov_sync.sv
// two-flop synchroniser for level signals
// assumes each bit is an independent level, or a word held stable by a handshake
`timescale 1ns/1ps
`default_nettype none

module iov_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = rst_n ? d : '0;
    q_d    = rst_n ? meta_q : '0;
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q      <= q_d;
  end

endmodule : iov_sync

`default_nettype wire

// File: iov_fault_handler.sv
// input over-voltage fault handler: thresholds, response machine, command port
// assumes VIN_LIN comes from core-clock logic; commands arrive on LINK_CLK
//
// Contract
// - hold 16-bit linear fault threshold at 0x55
// - hold 16-bit linear warning threshold at 0x57
// - response 00: keep running through the fault
// - response 01: ride delay, then retry if persisting
// - response 10: disable at once, then retry
// - response 11: disable until fault is cleared
// - clear on command, status clear, reset, off-on
// - retry code 000: never restart, stay off
// - codes 001-110: one to six attempts, then off
// - attempt spacing equals multiplier times time unit
// - code 111 retries until commanded off
// - delay code selects two to the code
// - time unit comes from register 0xD2
`timescale 1ns/1ps
`default_nettype none

module iov_fault_handler (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic                       LINK_CLK,
  input  wire logic [iov_pkg::DATA_W-1:0] VIN_LIN,
  input  wire logic                       OUT_ON,
  input  wire logic [iov_pkg::CMD_W-1:0]  CMD_CODE,
  input  wire logic                       CMD_WR,
  input  wire logic [iov_pkg::DATA_W-1:0] CMD_WDATA,
  input  wire logic                       CMD_RD,
  output logic      [iov_pkg::DATA_W-1:0] CMD_RDATA,
  output logic                            CMD_BUSY,
  output logic                            PWR_EN,
  output logic                            OV_FAULT,
  output logic                            OV_WARN
);
  import iov_pkg::*;

  // link domain: reset, held request and readback copies
  logic              link_rst_n;
  logic [DATA_W-1:0] fthr_l_q, fthr_l_d;
  logic [7:0]        act_l_q, act_l_d;
  logic [DATA_W-1:0] wthr_l_q, wthr_l_d;
  logic [DATA_W-1:0] unit_l_q, unit_l_d;
  logic [CMD_W-1:0]  req_code_q, req_code_d;
  logic [DATA_W-1:0] req_data_q, req_data_d;
  logic              req_tgl_q, req_tgl_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              busy_q, busy_d;
  logic              ack_l;
  logic [STAT_W-1:0] stat_l;
  logic              accept;

  iov_sync #(.W(1)) u_link_rst (
    .clk   (LINK_CLK),
    .rst_n (1'b1),
    .d     (RST_N),
    .q     (link_rst_n)
  );

  // core domain signals
  logic              req_s;
  logic              ack_tgl_q, ack_tgl_d;
  logic              on_s;
  logic              on_prev_q, on_prev_d;
  logic [DATA_W-1:0] fthr_q, fthr_d;
  logic [7:0]        act_q, act_d;
  logic [DATA_W-1:0] wthr_q, wthr_d;
  logic [DATA_W-1:0] unit_q, unit_d;
  logic              fault_q, fault_d;
  logic              warn_q, warn_d;
  logic [STAT_W-1:0] stat_byte;
  iov_state_t        state_q, state_d;
  logic [2:0]        tries_q, tries_d;
  logic              pwr_q, pwr_d;
  logic [6:0]        pre_q, pre_d;
  logic [DATA_W-1:0] ucnt_q, ucnt_d;
  logic [7:0]        tmr_q, tmr_d;
  logic              load;

  iov_sync #(.W(1)) u_ack_sync (
    .clk   (LINK_CLK),
    .rst_n (link_rst_n),
    .d     (ack_tgl_q),
    .q     (ack_l)
  );

  iov_sync #(.W(STAT_W)) u_stat_sync (
    .clk   (LINK_CLK),
    .rst_n (link_rst_n),
    .d     (stat_byte),
    .q     (stat_l)
  );

  // one write in flight; a write while busy is dropped, the host must poll busy
  assign accept = CMD_WR && (req_tgl_q == ack_l);

  always_comb begin
    fthr_l_d   = fthr_l_q;
    act_l_d    = act_l_q;
    wthr_l_d   = wthr_l_q;
    unit_l_d   = unit_l_q;
    req_code_d = req_code_q;
    req_data_d = req_data_q;
    req_tgl_d  = req_tgl_q;
    rdata_d    = rdata_q;
    if (accept) begin
      req_code_d = CMD_CODE;
      req_data_d = CMD_WDATA;
      req_tgl_d  = ~req_tgl_q;
      unique case (CMD_CODE)
        CMD_FAULT_THR: fthr_l_d = CMD_WDATA;
        CMD_ACTION:    act_l_d  = CMD_WDATA[7:0];
        CMD_WARN_THR:  wthr_l_d = CMD_WDATA;
        CMD_TIME_UNIT: unit_l_d = CMD_WDATA;
        default: ;
      endcase
    end
    if (CMD_RD) begin
      unique case (CMD_CODE)
        CMD_FAULT_THR: rdata_d = fthr_l_q;
        CMD_ACTION:    rdata_d = {8'h00, act_l_q};
        CMD_WARN_THR:  rdata_d = wthr_l_q;
        CMD_TIME_UNIT: rdata_d = unit_l_q;
        CMD_STATUS:    rdata_d = {8'h00, stat_l};
        default:       rdata_d = '0;
      endcase
    end
    busy_d = (req_tgl_d != ack_l);
    if (!link_rst_n) begin
      fthr_l_d   = FAULT_THR_RST;
      act_l_d    = ACTION_RST;
      wthr_l_d   = WARN_THR_RST;
      unit_l_d   = TIME_UNIT_RST;
      req_code_d = '0;
      req_data_d = '0;
      req_tgl_d  = 1'b0;
      rdata_d    = '0;
      busy_d     = 1'b0;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    fthr_l_q   <= fthr_l_d;
    act_l_q    <= act_l_d;
    wthr_l_q   <= wthr_l_d;
    unit_l_q   <= unit_l_d;
    req_code_q <= req_code_d;
    req_data_q <= req_data_d;
    req_tgl_q  <= req_tgl_d;
    rdata_q    <= rdata_d;
    busy_q     <= busy_d;
  end

  assign CMD_RDATA = rdata_q;
  assign CMD_BUSY  = busy_q;

  // core side of the write handshake; request words are stable while it is open
  iov_sync #(.W(1)) u_req_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (req_tgl_q),
    .q     (req_s)
  );

  iov_sync #(.W(1)) u_on_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (OUT_ON),
    .q     (on_s)
  );

  logic             wr;
  logic             wr_clear;
  logic             stat_clr_f;
  logic             stat_clr_w;
  logic             on_rise;
  logic             latch_clr;
  logic             over_f;
  logic             over_w;
  logic signed [47:0] vin_fix;
  iov_resp_t        resp;
  logic [2:0]       retries;
  logic [7:0]       mult;
  logic [DATA_W-1:0] unit_last;
  logic             tick;
  logic             expire;
  iov_state_t       retry_entry;

  assign wr         = (req_s != ack_tgl_q);
  assign wr_clear   = wr && (req_code_q == CMD_CLEAR_FAULTS);
  assign stat_clr_f = wr && (req_code_q == CMD_STATUS) && req_data_q[ST_FAULT_BIT];
  assign stat_clr_w = wr && (req_code_q == CMD_STATUS) && req_data_q[ST_WARN_BIT];
  assign on_rise    = on_s && !on_prev_q;
  assign latch_clr  = wr_clear || stat_clr_f || on_rise;

  assign vin_fix = iov_lin_to_fix(VIN_LIN);
  assign over_f  = vin_fix > iov_lin_to_fix(fthr_q);
  assign over_w  = vin_fix > iov_lin_to_fix(wthr_q);

  assign resp    = iov_resp_t'(act_q[RESP_MSB:RESP_LSB]);
  assign retries = act_q[RETRY_MSB:RETRY_LSB];
  assign mult    = iov_mult(act_q[DLY_MSB:DLY_LSB]);

  // configuration registers and sticky flags; a new event wins over a clear
  always_comb begin
    ack_tgl_d = req_s;
    on_prev_d = on_s;
    fthr_d    = fthr_q;
    act_d     = act_q;
    wthr_d    = wthr_q;
    unit_d    = unit_q;
    if (wr) begin
      unique case (req_code_q)
        CMD_FAULT_THR: fthr_d = req_data_q;
        CMD_ACTION:    act_d  = req_data_q[7:0];
        CMD_WARN_THR:  wthr_d = req_data_q;
        CMD_TIME_UNIT: unit_d = req_data_q;
        default: ;
      endcase
    end
    fault_d = over_f || (fault_q && !latch_clr);
    warn_d  = over_w || (warn_q && !(wr_clear || stat_clr_w || on_rise));
    if (!RST_N) begin
      ack_tgl_d = 1'b0;
      on_prev_d = 1'b0;
      fthr_d    = FAULT_THR_RST;
      act_d     = ACTION_RST;
      wthr_d    = WARN_THR_RST;
      unit_d    = TIME_UNIT_RST;
      fault_d   = 1'b0;
      warn_d    = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    ack_tgl_q <= ack_tgl_d;
    on_prev_q <= on_prev_d;
    fthr_q    <= fthr_d;
    act_q     <= act_d;
    wthr_q    <= wthr_d;
    unit_q    <= unit_d;
    fault_q   <= fault_d;
    warn_q    <= warn_d;
  end

  always_comb begin
    stat_byte               = '0;
    stat_byte[ST_FAULT_BIT] = fault_q;
    stat_byte[ST_WARN_BIT]  = warn_q;
  end

  // delay timer: microsecond prescale, then time unit, then multiplier
  assign unit_last = (unit_q == '0) ? '0 : unit_q - TIME_UNIT_RST;
  assign tick      = (pre_q == TICK_CYC_M1) && (ucnt_q >= unit_last);
  assign expire    = tick && (tmr_q == TMR_LAST);

  always_comb begin
    pre_d  = (pre_q == TICK_CYC_M1) ? '0 : 7'(pre_q + 7'h01);
    ucnt_d = ucnt_q;
    tmr_d  = tmr_q;
    if (pre_q == TICK_CYC_M1) begin
      ucnt_d = (ucnt_q >= unit_last) ? '0 : DATA_W'(ucnt_q + TIME_UNIT_RST);
    end
    if (tick && (tmr_q != '0)) begin
      tmr_d = 8'(tmr_q - TMR_LAST);
    end
    if (load) begin
      pre_d  = '0;
      ucnt_d = '0;
      tmr_d  = mult;
    end
    if (!RST_N) begin
      pre_d  = '0;
      ucnt_d = '0;
      tmr_d  = '0;
    end
  end

  always_ff @(posedge CLK) begin
    pre_q  <= pre_d;
    ucnt_q <= ucnt_d;
    tmr_q  <= tmr_d;
  end

  // response machine
  assign retry_entry = (retries == RETRY_NONE) ? ST_LATCH : ST_WAIT;

  always_comb begin
    state_d = state_q;
    tries_d = tries_q;
    pwr_d   = pwr_q;
    load    = 1'b0;
    if (!on_s) begin
      // commanded off ends any ride, retry run or latch
      state_d = ST_RUN;
      pwr_d   = 1'b0;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          pwr_d = 1'b1;
          if (over_f) begin
            unique case (resp)
              RESP_IGNORE: ;
              RESP_RIDE: begin
                state_d = ST_RIDE;
                load    = 1'b1;
              end
              RESP_RETRY: begin
                pwr_d   = 1'b0;
                state_d = retry_entry;
                tries_d = '0;
                load    = (retry_entry == ST_WAIT);
              end
              RESP_LATCH: begin
                pwr_d   = 1'b0;
                state_d = ST_LATCH;
              end
            endcase
          end
        end
        ST_RIDE: begin
          pwr_d = 1'b1;
          if (!over_f) begin
            state_d = ST_RUN;
          end else if (expire) begin
            pwr_d   = 1'b0;
            state_d = retry_entry;
            tries_d = '0;
            load    = (retry_entry == ST_WAIT);
          end
        end
        ST_WAIT: begin
          pwr_d = 1'b0;
          if (expire) begin
            tries_d = 3'(tries_q + 3'h1);
            if (!over_f) begin
              // restart inhibited while the input is still too high
              state_d = ST_RUN;
              pwr_d   = 1'b1;
            end else if ((retries == RETRY_ENDLESS) || (3'(tries_q + 3'h1) < retries)) begin
              load = 1'b1;
            end else begin
              state_d = ST_LATCH;
            end
          end
        end
        ST_LATCH: begin
          pwr_d = 1'b0;
          if (latch_clr) begin
            state_d = ST_RUN;
          end
        end
      endcase
    end
    if (!RST_N) begin
      state_d = ST_RUN;
      tries_d = '0;
      pwr_d   = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    state_q <= state_d;
    tries_q <= tries_d;
    pwr_q   <= pwr_d;
  end

  assign PWR_EN   = pwr_q;
  assign OV_FAULT = fault_q;
  assign OV_WARN  = warn_q;

  // checks on the core domain
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_IGNORE_RUNS: assert property (
    (on_s && state_q == ST_RUN && resp == RESP_IGNORE) ##1 on_s |-> pwr_q && state_q == ST_RUN)
    else $error("ignore response changed output");

  AST_RIDE_ON: assert property (
    (on_s && state_q == ST_RIDE && !(expire && over_f)) |=> pwr_q)
    else $error("output dropped during ride-through");

  AST_RIDE_END: assert property (
    (on_s && state_q == ST_RIDE && expire && over_f) |=> !pwr_q && state_q != ST_RIDE)
    else $error("ride-through end did not hand over to retry handling");

  AST_DISABLE_NOW: assert property (
    (on_s && state_q == ST_RUN && over_f && resp == RESP_RETRY) |=> !pwr_q && state_q != ST_RUN)
    else $error("disable-and-retry did not disable");

  AST_LATCH_HOLDS: assert property (
    (state_q == ST_LATCH && on_s && !latch_clr) |=> state_q == ST_LATCH && !pwr_q)
    else $error("latched fault released without a clear");

  AST_CLEAR_RELEASE: assert property (
    (state_q == ST_LATCH && on_s && wr_clear) |=> state_q == ST_RUN ##1 (pwr_q || !on_s))
    else $error("clear faults did not release latch");

  AST_NO_RETRY: assert property (
    (on_s && state_q == ST_RUN && over_f && resp == RESP_RETRY && retries == RETRY_NONE)
      |=> state_q == ST_LATCH)
    else $error("retry code zero attempted a restart");

  AST_TRY_LIMIT: assert property (
    (state_q == ST_WAIT && retries != RETRY_ENDLESS) |-> tries_q < retries)
    else $error("more restart attempts than programmed");

  AST_TIMER_LOAD: assert property (
    (load && RST_N) |=> tmr_q == $past(mult) && pre_q == '0)
    else $error("delay timer not loaded with multiplier");

  AST_FAULT_FLAG: assert property (
    over_f |=> fault_q)
    else $error("fault flag not set above threshold");

  AST_WARN_FLAG: assert property (
    (over_w && !over_f && state_q == ST_RUN && on_s) |=> warn_q && pwr_q)
    else $error("warning flag missing or output changed");

  COV_LATCH: cover property (state_q == ST_RUN ##1 state_q == ST_LATCH);
  COV_RIDE_EXPIRE: cover property (state_q == ST_RIDE && expire && over_f);
  COV_ENDLESS: cover property (state_q == ST_WAIT && expire && retries == RETRY_ENDLESS);
  COV_OFF_ON: cover property (on_rise && fault_q);

endmodule : iov_fault_handler

`default_nettype wire

// File: iov_host_model.sv
// host-side command master for the fault handler's link port
// assumes the bench calls wr and rd one at a time
`timescale 1ns/1ps
`default_nettype none

module iov_host_model (
  output var logic        link_clk,
  output var logic [7:0]  cmd_code,
  output var logic        cmd_wr,
  output var logic [15:0] cmd_wdata,
  output var logic        cmd_rd,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_busy
);
  // preset at declaration so a clk_on call at time zero is not undone
  logic run = 1'b0;

  // link clock stands low between frames
  initial begin
    link_clk  = 1'b0;
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_code  = 8'hFF;
    cmd_wdata = 16'hFFFF;
    #3;
    forever begin
      #16;
      if (run || link_clk) link_clk = ~link_clk;
    end
  end

  task automatic clk_on(input logic on);
    run = on;
  endtask : clk_on

  // idle edges let status sync settle and keep the post-reset gap
  task automatic lead();
    int k;
    run = 1'b1;
    repeat (3) @(posedge link_clk);
    for (k = 0; k < 64 && cmd_busy !== 1'b0; k++) @(posedge link_clk);
    @(negedge link_clk);
  endtask : lead

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    int k;
    lead();
    cmd_code  = c;
    cmd_wdata = d;
    cmd_wr    = 1'b1;
    @(posedge link_clk);
    @(negedge link_clk);
    cmd_wr    = 1'b0;
    cmd_code  = ~c;
    cmd_wdata = ~d;
    for (k = 0; k < 64 && cmd_busy !== 1'b0; k++) @(posedge link_clk);
    repeat (2) @(posedge link_clk);
    run = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    lead();
    cmd_code = c;
    cmd_rd   = 1'b1;
    @(posedge link_clk);
    @(negedge link_clk);
    cmd_rd   = 1'b0;
    cmd_code = ~c;
    d        = cmd_rdata;
    run      = 1'b0;
  endtask : rd
endmodule : iov_host_model

`default_nettype wire

// File: iov_fault_handler_tb_top.sv
// self-checking bench for the input over-voltage fault handler
// assumes thresholds in linear format with exponent zero
`timescale 1ns/1ps
`default_nettype none

module iov_fault_handler_tb_top;
  import iov_pkg::*;
  logic        clk, rst_n, out_on, lclk, wr, rd, busy, pwr, flt, wrn;
  logic [15:0] vin, wdata, rdata, r, v;
  logic [7:0]  code;
  int          n_errors, n_tests, cyc, seed, n, i, d, u, iv;
  int          tn[12] = '{0, 1, 1, 3, 3, 6, 6, 7, 0, 0, 0, 0};
  int          tm[12] = '{0, 0, 1, 2, 3, 5, 6, 8, 0, 0, 0, 0};

  iov_fault_handler iov_fault_handler_inst (.CLK(clk), .RST_N(rst_n), .LINK_CLK(lclk),
    .VIN_LIN(vin), .OUT_ON(out_on), .CMD_CODE(code), .CMD_WR(wr), .CMD_WDATA(wdata),
    .CMD_RD(rd), .CMD_RDATA(rdata), .CMD_BUSY(busy), .PWR_EN(pwr), .OV_FAULT(flt),
    .OV_WARN(wrn));
  iov_host_model iov_host_model_inst (.link_clk(lclk), .cmd_code(code), .cmd_wr(wr),
    .cmd_wdata(wdata), .cmd_rd(rd), .cmd_rdata(rdata), .cmd_busy(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic int ivl(input int dc, input int un);
    return (1 << dc) * (un == 0 ? 1 : un) * 100;
  endfunction : ivl

  function automatic logic recov(input int nr, input int m);
    return nr == 7 || m < nr;
  endfunction : recov

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int e, input int g, input int tol);
    n_tests++;
    if (g < e - tol || g > e + tol) begin
      $display("Error %s expected %0d seen %0d", nm, e, g);
      n_errors++;
    end
  endtask : chk_rng

  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask : idle

  task automatic setv(input logic [15:0] x);
    @(negedge clk);
    vin = x;
  endtask : setv

  task automatic pin(input logic on);
    @(negedge clk);
    out_on = on;
  endtask : pin

  task automatic wait_pwr(input logic x, input int lim);
    n = 0;
    while (pwr !== x && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_pwr

  // link clock must run through reset so the link side sees it
  task automatic do_reset();
    iov_host_model_inst.clk_on(1'b1);
    @(negedge clk);
    rst_n = 1'b0;
    idle(12);
    rst_n = 1'b1;
    idle(2);
    iov_host_model_inst.clk_on(1'b0);
  endtask : do_reset

  task automatic setup_thr();
    iov_host_model_inst.wr(CMD_FAULT_THR, 16'h0064);
    iov_host_model_inst.wr(CMD_WARN_THR, 16'h0050);
  endtask : setup_thr

  task automatic recover();
    pin(1'b0);
    idle(5);
    out_on = 1'b1;
    vin = 16'h0032;
    iov_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
    wait_pwr(1'b1, 30);
  endtask : recover

  initial begin
    seed = 32'h08AD706E;
    vin = 16'h0032;
    out_on = 1'b1;
    rst_n = 1'b0;
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    do_reset();
    chk("busy_rst", 16'h0000, {15'h0, busy});
    iov_host_model_inst.rd(CMD_FAULT_THR, r);
    chk("fault_thr_rst", FAULT_THR_RST, r);
    iov_host_model_inst.rd(CMD_WARN_THR, r);
    chk("warn_thr_rst", WARN_THR_RST, r);
    iov_host_model_inst.rd(CMD_ACTION, r);
    chk("action_rst", {8'h00, ACTION_RST}, r);
    iov_host_model_inst.rd(CMD_TIME_UNIT, r);
    chk("unit_rst", TIME_UNIT_RST, r);
    iov_host_model_inst.rd(8'h99, r);
    chk("unmapped", 16'h0000, r);
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      iov_host_model_inst.wr(CMD_FAULT_THR, v);
      iov_host_model_inst.rd(CMD_FAULT_THR, r);
      chk("fault_thr", v, r);
      iov_host_model_inst.wr(CMD_WARN_THR, ~v);
      iov_host_model_inst.rd(CMD_WARN_THR, r);
      chk("warn_thr", ~v, r);
    end
    setup_thr();
    recover();
    $display("test registers done");
    setv(16'h005A);
    idle(10);
    chk("warn", 16'h0001, {15'h0, wrn});
    chk("warn_no_fault", 16'h0000, {15'h0, flt});
    chk("warn_pwr", 16'h0001, {15'h0, pwr});
    setv(16'h0096);
    idle(10);
    chk("fault", 16'h0001, {15'h0, flt});
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (pwr !== 1'b1) n++;
    end
    chk_rng("ignore_drops", 0, n, 0);
    iov_host_model_inst.rd(CMD_STATUS, r);
    chk("status", 16'h00A0, r);
    setv(16'h0032);
    iov_host_model_inst.wr(CMD_STATUS, 16'h0020);
    iov_host_model_inst.rd(CMD_STATUS, r);
    chk("status_w1c", 16'h0080, r);
    setv(16'h0032);
    iov_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
    iov_host_model_inst.rd(CMD_STATUS, r);
    chk("status_clr", 16'h0000, r);
    for (i = 0; i < 6; i++) begin
      v = {5'h00, 11'($random(seed))};
      setv(v);
      idle(6);
      chk("rand_fault", {15'h0, $signed(v[10:0]) > 11'sd100}, {15'h0, flt});
      setv(16'h0032);
      iov_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
    end
    $display("test ignore and warn done");
    iov_host_model_inst.wr(CMD_ACTION, 16'h00C0);
    for (i = 0; i < 4; i++) begin
      setv(16'h0096);
      wait_pwr(1'b0, 10);
      chk("latch_off", 16'h0000, {15'h0, pwr});
      setv(16'h0032);
      idle(200);
      chk("latch_hold", 16'h0000, {15'h0, pwr});
      case (i)
        0: iov_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
        1: iov_host_model_inst.wr(CMD_STATUS, 16'h0080);
        2: begin
          pin(1'b0);
          idle(5);
          out_on = 1'b1;
        end
        default: do_reset();
      endcase
      wait_pwr(1'b1, 30);
      chk("latch_clear", 16'h0001, {15'h0, pwr});
    end
    setup_thr();
    $display("test latch done");
    iov_host_model_inst.wr(CMD_ACTION, 16'h0041);
    setv(16'h0096);
    idle(100);
    setv(16'h0032);
    idle(300);
    chk("ride_short", 16'h0001, {15'h0, pwr});
    iov_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
    setv(16'h0096);
    idle(ivl(1, 1) - 20);
    chk("ride_hold", 16'h0001, {15'h0, pwr});
    idle(40);
    chk("ride_off", 16'h0000, {15'h0, pwr});
    recover();
    $display("test ride done");
    for (i = 0; i < 5; i++) begin
      u = i == 4 ? 2 : 1;
      d = i == 4 ? 0 : i;
      iv = ivl(d, u);
      iov_host_model_inst.wr(CMD_TIME_UNIT, 16'(u));
      iov_host_model_inst.wr(CMD_ACTION, 16'h0088 | 16'(d));
      setv(16'h0096);
      wait_pwr(1'b0, 6);
      chk("retry_off", 16'h0000, {15'h0, pwr});
      setv(16'h0032);
      wait_pwr(1'b1, iv + 50);
      chk_rng("interval", iv, n + 1, 4);
      iov_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
    end
    iov_host_model_inst.rd(CMD_TIME_UNIT, r);
    chk("unit", 16'h0002, r);
    iov_host_model_inst.wr(CMD_TIME_UNIT, 16'h0001);
    $display("test interval done");
    for (i = 0; i < 12; i++) begin
      if (i >= 8) begin
        tn[i] = $random(seed) & 7;
        tm[i] = $random(seed) & 7;
      end
      d = i % 2;
      iv = ivl(d, 1);
      iov_host_model_inst.wr(CMD_ACTION, 16'h0080 | 16'(tn[i] << 3) | 16'(d));
      setv(16'h0096);
      wait_pwr(1'b0, 6);
      idle(tm[i] * iv + iv / 2);
      setv(16'h0032);
      wait_pwr(1'b1, iv);
      chk("retry_count", {15'h0, recov(tn[i], tm[i])}, {15'h0, pwr});
      recover();
    end
    $display("test retry counts done");
    wrap_up();
  end
endmodule : iov_fault_handler_tb_top

`default_nettype wire
